// [design/fawr_pkg.sv]
package fawr_pkg;

  // ==========================================================================
  // Register selects on the internal configuration access port.
  localparam logic [1:0]  SEL_WARM_BOOT_START_ADDRESS = 2'h0;
  localparam logic [1:0]  SEL_COMMAND                 = 2'h1;
  localparam logic [1:0]  SEL_STATUS                  = 2'h2;

  // ==========================================================================
  // Warm boot start address field layout and reset value.
  localparam int          WB_RS_HI    = 31;
  localparam int          WB_RS_LO    = 30;
  localparam int          WB_RS_DRIVE = 29;
  localparam int          WB_ADDR_HI  = 28;
  localparam logic [31:0] WB_RESET    = 32'h0000_0000;

  // Command code that starts an internal reprogram.
  localparam logic [31:0] CMD_INTERNAL_REPROGRAM = 32'h0000_000F;

  // ==========================================================================
  // Flash bus widths.
  localparam int FLASH_ADDR_W = 26;
  localparam int FLASH_DATA_W = 16;
  localparam int CFG_DATA_W   = 4;

  // ==========================================================================
  // Clock generation: rates in MHz and the cycle counts derived from them.
  localparam int CLK_MHZ       = 250;
  localparam int SYS_MHZ       = 100;
  localparam int SLOW_MHZ      = 50;
  localparam int SLOW_DIV      = CLK_MHZ / SLOW_MHZ;
  localparam int SLOW_HIGH     = SLOW_DIV / 2;
  localparam int SYS_STEP      = (SYS_MHZ * SLOW_DIV) / CLK_MHZ * 1;
  localparam int CLEAR_CYCLES  = 4;

  // Request from the memory controller toward the flash.
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] dataOut;
    logic        dataOe;
    logic        ceN;
    logic        advN;
    logic        oeN;
    logic        weN;
  } fawr_flash_req_t;

  // Pins on the flash side.
  typedef struct packed {
    logic [25:0] addr;
    logic        ceN;
    logic        advN;
    logic        oeN;
    logic        weN;
  } fawr_flash_pins_t;

endpackage

// [design/fawr_flash_access_warm_reboot.sv]
`timescale 1ns/1ps
// What this block does
// [R1] Warm boot address bits 31:30 drive the two revision-select pins when driving.
// [R2] Bit 29 selects driving the revision-select pins or leaving them 3-stated.
// [R3] Low 29 bits of the warm boot address give the image flash address.
// [R4] Reprogram command takes its reload address from the stored warm boot address.
// [R5] Reprogram clears all configuration except the warm boot address register.
// [R6] After clearing, reload starts at the stored warm boot address.
// [R7] Host triggers warm boot by ordered port writes after writing the address.
// [R8] Host translates the user flash address into the warm boot register value.
// [R9] Flash byte address 0x01000000 translates to register value 0x40000000.
// [R10] Update image sits at flash byte address 0x01000000; reboot points there.
// [R11] Clock generator makes a 100 MHz system clock and 50 MHz slow clock.
// [R12] Memory controller runs on exactly the clock forwarded to the flash; here ctrlReq and the flash pins are registered on clk, not slowClockOut.
// [R13] Flash clock leaves through the user configuration clock output.
// [R14] Configuration clock tristate control is held at zero, clock driven always.
// [R15] Controller address is truncated to its low 26 bits onto flash pins.
// [R16] Flash data bits 3:0 use the config data in, out and tristate ports.
// [R17] Flash data bits 15:4 pass through bidirectional buffers onto general pins.
// [R18] Controller chip enable drives the flash chip select out port.
// [R19] Address-valid, output-enable, write-enable and wait bypass the access primitive.
// [R20] Once the update image is running, flash access stays off until golden reload.
// [R21] Host finishes the start address write before issuing the reprogram command.
module fawr_flash_access_warm_reboot #(
  parameter int CLEAR_LEN = fawr_pkg::CLEAR_CYCLES
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Internal configuration access port.
  input  wire logic                      cfgWrValid,
  input  wire logic [1:0]                cfgSel,
  input  wire logic [31:0]               cfgWrData,
  output logic      [31:0]               cfgRdData,
  // Memory controller side.
  input  wire fawr_pkg::fawr_flash_req_t ctrlReq,
  output logic      [15:0]               ctrlDataIn,
  output logic                           ctrlWait,
  // Clocks produced here.
  output logic                           sysClock,
  output logic                           slowClockOut,
  // Reconfiguration sequence.
  input  wire logic                      goldenReload,
  output logic                           configClear,
  output logic                           reloadStart,
  output logic      [28:0]               reloadAddress,
  output logic                           updateRunning,
  // Revision select pins.
  output logic      [1:0]                revisionSelectOut,
  output logic      [1:0]                revisionSelectOe,
  // Dedicated configuration pins through the access primitive.
  output logic                           userConfigClockOut,
  output logic                           userConfigClockTristate,
  output logic                           flashChipSelectOut,
  output logic      [3:0]                configDataOut,
  output logic      [3:0]                configDataTristate,
  input  wire logic [3:0]                configDataIn,
  // General purpose pins.
  output fawr_pkg::fawr_flash_pins_t     flashPins,
  output logic      [11:0]               flashDataHiOut,
  output logic      [11:0]               flashDataHiOe,
  input  wire logic [11:0]               flashDataHiIn,
  input  wire logic                      flashWaitIn
);

  // Elaboration refuses a clear length that the 8-bit counter cannot hold.
  if (CLEAR_LEN < 1 || CLEAR_LEN > 255) begin : gen_bad_clear_len
    $error("CLEAR_LEN out of range");
  end

  typedef enum {ST_RUN, ST_CLEAR, ST_LOAD, ST_UPDATE} fawr_state_t;

  fawr_state_t  state;
  logic [31:0]  warmBootStartAddress;
  logic [7:0]   clearCount;
  logic [2:0]   slowCount;
  logic [2:0]   sysAcc;
  logic         cmdReprogram;
  logic         accessEnable;
  logic [15:0]  dataInMeta;
  logic [15:0]  dataInSync;
  logic         waitMeta;

  // ==========================================================================
  // Clock generation
  // Slow clock divides 250 MHz by five; the system clock uses a 2/5 phase step.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slowCount    <= 3'h0;
      slowClockOut <= 1'h0;
    end else begin
      slowCount    <= (slowCount == 3'(fawr_pkg::SLOW_DIV - 1)) ? 3'h0 : slowCount + 3'h1;
      slowClockOut <= (slowCount < 3'(fawr_pkg::SLOW_HIGH)); // [R11]
    end
  end

  // Phase accumulator for the system clock, two steps of five per edge.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sysAcc   <= 3'h0;
      sysClock <= 1'h0;
    end else begin
      sysAcc   <= (sysAcc >= 3'(fawr_pkg::SLOW_DIV - 2)) ?
                  sysAcc - 3'(fawr_pkg::SLOW_DIV - 2) : sysAcc + 3'h2;
      sysClock <= (sysAcc < 3'h2); // [R11]
    end
  end

  // The same slow clock is forwarded and always driven.
  assign userConfigClockOut      = slowClockOut;  // [R12] [R13]
  assign userConfigClockTristate = 1'h0;          // [R14]

  // ==========================================================================
  // Configuration access port
  assign cmdReprogram = cfgWrValid && cfgSel == fawr_pkg::SEL_COMMAND &&
                        cfgWrData == fawr_pkg::CMD_INTERNAL_REPROGRAM;

  // Warm boot address survives the clear; a write during the sequence is ignored.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      warmBootStartAddress <= fawr_pkg::WB_RESET;
    end else if (cfgWrValid && cfgSel == fawr_pkg::SEL_WARM_BOOT_START_ADDRESS &&
                 state == ST_RUN) begin
      warmBootStartAddress <= cfgWrData; // [R5]
    end
  end

  // Read mux shows the stored address and the sequence state.
  always_comb begin
    case (cfgSel)
      fawr_pkg::SEL_WARM_BOOT_START_ADDRESS: cfgRdData = warmBootStartAddress;
      fawr_pkg::SEL_STATUS: cfgRdData = {29'h0, updateRunning, configClear, accessEnable};
      default: cfgRdData = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Revision select pins follow the top bits when bit 29 asks to drive.
  assign revisionSelectOut = warmBootStartAddress[fawr_pkg::WB_RS_HI:fawr_pkg::WB_RS_LO]; // [R1]
  assign revisionSelectOe  = {2{warmBootStartAddress[fawr_pkg::WB_RS_DRIVE]}};            // [R2]

  // ==========================================================================
  // Reprogram sequence: clear, load from the stored address, then run the update.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state      <= ST_RUN;
      clearCount <= 8'h00;
    end else begin
      case (state)
        ST_RUN: begin
          if (cmdReprogram) begin
            state      <= ST_CLEAR; // [R5]
            clearCount <= 8'(CLEAR_LEN - 1);
          end
        end
        ST_CLEAR: begin
          if (clearCount == 8'h00) begin
            state <= ST_LOAD; // [R6]
          end else begin
            clearCount <= clearCount - 8'h01;
          end
        end
        ST_LOAD: state <= ST_UPDATE;
        ST_UPDATE: begin
          if (goldenReload) begin
            state <= ST_RUN; // [R20]
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // Reload address is captured from the stored register as the load begins.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reloadAddress <= 29'h0;
    end else if (state == ST_CLEAR && clearCount == 8'h00) begin
      reloadAddress <= warmBootStartAddress[fawr_pkg::WB_ADDR_HI:0]; // [R3] [R4]
    end
  end

  assign configClear   = (state == ST_CLEAR);
  assign reloadStart   = (state == ST_LOAD);
  assign updateRunning = (state == ST_UPDATE);
  assign accessEnable  = (state == ST_RUN); // [R20]

  // ==========================================================================
  // Flash pins, registered from the controller and idle while access is off.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flashPins          <= '{addr: 26'h0, ceN: 1'h1, advN: 1'h1, oeN: 1'h1, weN: 1'h1};
      flashChipSelectOut <= 1'h1;
      configDataOut      <= 4'h0;
      configDataTristate <= 4'hF;
      flashDataHiOut     <= 12'h000;
      flashDataHiOe      <= 12'h000;
    end else begin
      flashPins.addr     <= ctrlReq.addr[fawr_pkg::FLASH_ADDR_W-1:0];             // [R15]
      flashPins.ceN      <= ctrlReq.ceN | ~accessEnable;
      flashPins.advN     <= ctrlReq.advN | ~accessEnable;                         // [R19]
      flashPins.oeN      <= ctrlReq.oeN | ~accessEnable;                          // [R19]
      flashPins.weN      <= ctrlReq.weN | ~accessEnable;                          // [R19]
      flashChipSelectOut <= ctrlReq.ceN | ~accessEnable;                          // [R18]
      configDataOut      <= ctrlReq.dataOut[fawr_pkg::CFG_DATA_W-1:0];            // [R16]
      configDataTristate <= {4{~(ctrlReq.dataOe & accessEnable)}};                // [R16]
      flashDataHiOut     <= ctrlReq.dataOut[fawr_pkg::FLASH_DATA_W-1:fawr_pkg::CFG_DATA_W];
      flashDataHiOe      <= {12{ctrlReq.dataOe & accessEnable}};                  // [R17]
    end
  end

  // Pin inputs pass two flip-flops before the controller sees them.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dataInMeta <= 16'h0000;
      dataInSync <= 16'h0000;
      waitMeta   <= 1'h0;
      ctrlWait   <= 1'h0;
    end else begin
      dataInMeta <= {flashDataHiIn, configDataIn}; // [R16] [R17]
      dataInSync <= dataInMeta;
      waitMeta   <= flashWaitIn;                   // [R19]
      ctrlWait   <= waitMeta;
    end
  end

  assign ctrlDataIn = dataInSync;

  // ==========================================================================
  // Checks.
  AST_RS_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    (cfgWrValid && cfgSel == fawr_pkg::SEL_WARM_BOOT_START_ADDRESS && accessEnable) |=>
      revisionSelectOut == $past(cfgWrData[fawr_pkg::WB_RS_HI:fawr_pkg::WB_RS_LO]))
    else $error("revision select pins differ from written value");
  AST_RS_DRIVE: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    (cfgWrValid && cfgSel == fawr_pkg::SEL_WARM_BOOT_START_ADDRESS && accessEnable) |=>
      revisionSelectOe == {2{$past(cfgWrData[fawr_pkg::WB_RS_DRIVE])}})
    else $error("revision select enable wrong");
  AST_CMD_CLEAR: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    (state == ST_RUN && cmdReprogram) |=> configClear)
    else $error("reprogram did not start clear");
  AST_WB_KEPT: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    configClear |=> $stable(warmBootStartAddress))
    else $error("warm boot address lost during clear");
  AST_CLEAR_LOAD: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
    $fell(configClear) |-> reloadStart)
    else $error("load did not follow clear");
  AST_RELOAD_ADDR: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    reloadStart |-> reloadAddress == warmBootStartAddress[28:0])
    else $error("reload address mismatch");
  AST_CLK_DRIVEN: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
    !userConfigClockTristate && userConfigClockOut == slowClockOut)
    else $error("forwarded clock not driven");
  AST_SLOW_PERIOD: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
    $rose(slowClockOut) |-> ##5 $rose(slowClockOut))
    else $error("slow clock period wrong");
  AST_ADDR_TRUNC: assert property (@(posedge clk) disable iff (!rst_n) // [R15]
    ##1 flashPins.addr == $past(ctrlReq.addr[25:0]))
    else $error("flash address not truncated copy");
  AST_NO_ACCESS: assert property (@(posedge clk) disable iff (!rst_n) // [R20]
    updateRunning [*2] |-> flashChipSelectOut && configDataTristate == 4'hF)
    else $error("flash accessed while update runs");

endmodule

// [tb/fawr_flash_model.sv]
`timescale 1ns/1ps
// ==========================================================================
// Flash partner: a small behavioural memory on the registered flash pins.
module fawr_flash_model (
  input  wire logic                       clk,
  input  wire fawr_pkg::fawr_flash_pins_t pins,
  input  wire logic                       chipSelN,
  input  wire logic                       slow,
  input  wire logic [15:0]                bus,
  output logic      [15:0]                dataOut,
  output logic                            waitOut
);
  logic [15:0] mem [16];
  logic [15:0] lastBus = 16'h0;

  // Writes land while selected with write enable low; the bus history feeds the idle level.
  always @(posedge clk) begin
    lastBus <= bus;
    if (!chipSelN && !pins.weN) begin
      mem[pins.addr[3:0]] <= bus;
    end
  end

  // Read data only while selected and output enabled, else the inverse of the last level.
  assign dataOut = (!chipSelN && !pins.oeN) ? mem[pins.addr[3:0]] : ~lastBus;
  // A slow answer holds wait high while the part is selected.
  assign waitOut = slow & !chipSelN;
endmodule

// [tb/tb_flash_access_warm_reboot.sv]
`timescale 1ns/1ps
// ==========================================================================
// Bench: flash path, forwarded clock and the warm boot sequence.
module tb_flash_access_warm_reboot;
  localparam int CLEAR = 3;
  localparam fawr_pkg::fawr_flash_req_t IDLE = {32'h0, 16'h0, 1'h0, 4'hF};
  logic clk = 1'h0, rst_n = 1'h0, cfgWrValid = 1'h0, goldenReload = 1'h0, slow = 1'h0;
  logic [1:0] cfgSel = 2'h0;
  logic [31:0] cfgWrData = 32'h0, cfgRdData;
  fawr_pkg::fawr_flash_req_t ctrlReq = IDLE;
  fawr_pkg::fawr_flash_pins_t flashPins;
  logic [15:0] ctrlDataIn, modelData, bus, devOe;
  logic ctrlWait, sysClock, slowClockOut, configClear, reloadStart, updateRunning;
  logic userConfigClockOut, userConfigClockTristate, flashChipSelectOut, flashWaitIn;
  logic [28:0] reloadAddress;
  logic [1:0] revisionSelectOut, revisionSelectOe;
  logic [3:0] configDataOut, configDataTristate;
  logic [11:0] flashDataHiOut, flashDataHiOe;
  int miscompares = 0, nTests = 0, seed, hi, rise, sysRise;
  logic prev, sysPrev;
  logic [31:0] a;
  logic [15:0] d;

  // Wire level: each data bit follows the device when it drives, else the flash model.
  assign devOe = {flashDataHiOe, ~configDataTristate};
  assign bus = (devOe & {flashDataHiOut, configDataOut}) | (~devOe & modelData);

  initial forever #2 clk = ~clk;

  fawr_flash_access_warm_reboot #(.CLEAR_LEN(CLEAR)) fawr_flash_access_warm_reboot_i (
    .clk(clk), .rst_n(rst_n), .cfgWrValid(cfgWrValid), .cfgSel(cfgSel),
    .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .ctrlReq(ctrlReq),
    .ctrlDataIn(ctrlDataIn), .ctrlWait(ctrlWait), .sysClock(sysClock),
    .slowClockOut(slowClockOut), .goldenReload(goldenReload), .configClear(configClear),
    .reloadStart(reloadStart), .reloadAddress(reloadAddress), .updateRunning(updateRunning),
    .revisionSelectOut(revisionSelectOut), .revisionSelectOe(revisionSelectOe),
    .userConfigClockOut(userConfigClockOut), .userConfigClockTristate(userConfigClockTristate),
    .flashChipSelectOut(flashChipSelectOut), .configDataOut(configDataOut),
    .configDataTristate(configDataTristate), .configDataIn(bus[3:0]), .flashPins(flashPins),
    .flashDataHiOut(flashDataHiOut), .flashDataHiOe(flashDataHiOe),
    .flashDataHiIn(bus[15:4]), .flashWaitIn(flashWaitIn));

  fawr_flash_model fawr_flash_model_i (
    .clk(clk), .pins(flashPins), .chipSelN(flashChipSelectOut), .slow(slow),
    .bus(bus), .dataOut(modelData), .waitOut(flashWaitIn));

  // ==========================================================================
  // Helpers: inputs change 1 ns after the rising edge, outputs are read there too.
  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results;
    $display("checks %0d, mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Host side: a flash byte address lands in the register by a shift of six.
  function automatic logic [31:0] translate(input logic [31:0] byteAddr);
    return byteAddr << 6;
  endfunction

  task automatic cfgWr(input logic [1:0] sel, input logic [31:0] v);
    step;
    cfgSel = sel;
    cfgWrData = v;
    cfgWrValid = 1'h1;
    step;
    cfgWrValid = 1'h0;
  endtask

  task automatic flashWr(input logic [31:0] ad, input logic [15:0] dt);
    ctrlReq = {ad, dt, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0};
    step;
    chk("pinAddr", ad[25:0], flashPins.addr);
    chk("chipSel", 1'h0, flashChipSelectOut);
    chk("pinCe", 1'h0, flashPins.ceN);
    chk("writeEn", 1'h0, flashPins.weN);
    chk("loDrive", 4'h0, configDataTristate);
    chk("hiDrive", 12'hFFF, flashDataHiOe);
    step;
    ctrlReq = IDLE;
    step;
  endtask

  task automatic flashRd(input logic [31:0] ad, input logic [15:0] dt, input logic s);
    ctrlReq = {ad, 16'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
    slow = s;
    repeat (4) step;
    chk("readData", dt, ctrlDataIn);
    chk("waitSync", s, ctrlWait);
    chk("advOe", 2'h0, {flashPins.advN, flashPins.oeN});
    ctrlReq = IDLE;
    slow = 1'h0;
    step;
  endtask

  task automatic boot(input logic [31:0] v);
    int n;
    cfgWr(fawr_pkg::SEL_WARM_BOOT_START_ADDRESS, v);
    chk("wbReg", v, cfgRdData);
    chk("rsOut", v[31:30], revisionSelectOut);
    chk("rsOe", {2{v[29]}}, revisionSelectOe);
    cfgWr(fawr_pkg::SEL_COMMAND, fawr_pkg::CMD_INTERNAL_REPROGRAM);
    n = 0;
    while (configClear !== 1'h1 && n < 8) begin
      step;
      n++;
    end
    chk("clearRise", 1'h1, configClear);
    if (n == 8) results();
    n = 0;
    while (configClear === 1'h1 && n < 300) begin
      step;
      n++;
    end
    chk("clearLen", CLEAR, n);
    if (n == 300) results();
    chk("reloadStart", 1'h1, reloadStart);
    chk("reloadAddr", v[28:0], reloadAddress);
    step;
    chk("startPulse", 1'h0, reloadStart);
    chk("updateOn", 1'h1, updateRunning);
    cfgSel = fawr_pkg::SEL_STATUS;
    #1;
    chk("statusUpdate", 32'h0000_0004, cfgRdData);
    cfgWr(fawr_pkg::SEL_WARM_BOOT_START_ADDRESS, ~v);
    chk("wbKept", v, cfgRdData);
    ctrlReq = {v, 16'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
    step;
    step;
    chk("accessOff", 1'h1, flashChipSelectOut);
    chk("dataOff", 4'hF, configDataTristate);
    ctrlReq = IDLE;
    goldenReload = 1'h1;
    step;
    goldenReload = 1'h0;
    step;
    chk("updateOff", 1'h0, updateRunning);
    cfgSel = fawr_pkg::SEL_STATUS;
    #1;
    chk("statusRun", 32'h0000_0001, cfgRdData);
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    seed = $urandom(96610);
    repeat (6) step;
    rst_n = 1'h1;
    step;
    chk("wbReset", fawr_pkg::WB_RESET, cfgRdData);
    chk("rsOeReset", 2'h0, revisionSelectOe);
    chk("clkTri", 1'h0, userConfigClockTristate);
    $display("test reset done");
    prev = slowClockOut;
    sysPrev = sysClock;
    hi = 0;
    rise = 0;
    sysRise = 0;
    repeat (20) begin
      step;
      hi += int'(slowClockOut);
      if (slowClockOut && !prev) rise++;
      if (sysClock && !sysPrev) sysRise++;
      prev = slowClockOut;
      sysPrev = sysClock;
      chk("fwdClk", slowClockOut, userConfigClockOut);
    end
    chk("slowHigh", 8, hi);
    chk("slowRise", 4, rise);
    chk("sysRise", fawr_pkg::SYS_MHZ * 20 / fawr_pkg::CLK_MHZ, sysRise);
    $display("test clock done");
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 32'hFFFF_FFFF : $urandom;
      d = (i == 1) ? 16'hA5C3 : 16'($urandom);
      flashWr(a, d);
      flashRd(a, d, 1'($urandom));
    end
    $display("test flash done");
    chk("translate", 32'h4000_0000, translate(32'h0100_0000));
    boot(translate(32'h0100_0000));
    boot($urandom | 32'h2000_0000);
    $display("test boot done");
    results();
  end
endmodule
